// File: tb/fpio_front_partner.sv
`timescale 1ns/1ps
// stand-in for the mezzanine board and the backplane trigger and sync lines
module fpio_front_partner (
  input  wire logic        mclk,            // system clock
  input  wire logic [34:0] want,            // levels: sync, trigger two, trigger one, mezzanine bus
  output logic      [31:0] mezzIn,          // mezzanine input bus
  output logic             triggerOneLine,  // trigger one line
  output logic             triggerTwoLine,  // trigger two line
  output logic             syncLine         // sync line
);
  // lines move just after an edge, so the synchroniser never sees a tie with the clock
  always @(posedge mclk) begin
    {syncLine, triggerTwoLine, triggerOneLine, mezzIn} <= want;
  end
endmodule : fpio_front_partner

// File: tb/test_front_panel_io_value_status.sv
`timescale 1ns/1ps
module test_front_panel_io_value_status;
  logic        mclk, srst, regWrite, regRead, regRdValid, trigOne, trigTwo, syncLv;
  logic [15:0] regAddr;
  logic [31:0] regWdata, regRdata, userLvds, userMezz, lvdsOut, mezzOut, mezzIn, d;
  logic [34:0] want, p;
  int          nMismatch, cmpCount;
  logic [15:0] zeroAt [8] = '{16'h0040, 16'h0044, 16'h0010, 16'h0014, 16'h0060, 16'h0064, 16'h0068, 16'h006C};
  logic [34:0] pats [2] = '{{3'b101, 32'hC3C3_5A5A}, {3'b010, 32'h3C3C_A5A5}};

  fpio_regs fpio_regs_inst (.mclk(mclk), .srst(srst), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regRdValid(regRdValid),
    .userLvds(userLvds), .userMezz(userMezz), .lvdsOut(lvdsOut), .mezzOut(mezzOut), .mezzIn(mezzIn),
    .triggerOneLine(trigOne), .triggerTwoLine(trigTwo), .syncLine(syncLv));
  fpio_front_partner fpio_front_partner_inst (.mclk(mclk), .want(want), .mezzIn(mezzIn),
    .triggerOneLine(trigOne), .triggerTwoLine(trigTwo), .syncLine(syncLv));

  // 40 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [15:0] a, input logic [31:0] v);
    @(posedge mclk);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= v;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask : wr

  // the strobe is one cycle; valid data shows straight after the taking edge
  task rd(input logic [15:0] a, output logic [31:0] v);
    @(posedge mclk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRead <= 1'b0;
    #1;
    chk({31'h0, regRdValid}, 32'h1);
    v = regRdata;
  endtask : rd

  task close_out;
    $display("mismatches %0d compares %0d", nMismatch, cmpCount);
    if (nMismatch == 0 && cmpCount > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  // a full run needs well under a thousand cycles
  initial begin
    #(25 * 3000);
    nMismatch++;
    close_out();
  end

  initial begin
    srst = 1'b1; regWrite = 1'b0; regRead = 1'b0; regAddr = '0; regWdata = '0;
    userLvds = '0; userMezz = '0; want = '0;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    foreach (zeroAt[i]) begin
      rd(zeroAt[i], d);
      chk(d, 32'h0);
    end
    wr(16'h0040, 32'hA5A5_0F0F);
    @(posedge mclk); #1 chk(lvdsOut, 32'hA5A5_0F0F);
    userLvds <= 32'h1234_5678;
    wr(16'h0010, 32'hFFFF_0000);
    @(posedge mclk); #1 chk(lvdsOut, 32'h1234_0F0F);
    userMezz <= 32'h89AB_CDEF;
    wr(16'h0044, 32'h0000_FFFF);
    @(posedge mclk); #1 chk(mezzOut, 32'h0000_FFFF);
    wr(16'h0014, 32'h00FF_00FF);
    @(posedge mclk); #1 chk(mezzOut, 32'h00AB_FFEF);
    rd(16'h0040, d); chk(d, 32'hA5A5_0F0F);
    rd(16'h0014, d); chk(d, 32'h00FF_00FF);
    // two opposite patterns so no bit passes by being stuck
    foreach (pats[k]) begin
      p = pats[k];
      want <= p;
      repeat (4) @(posedge mclk);
      rd(16'h0060, d); chk(d, p[31:0]);
      rd(16'h0064, d); chk(d, {31'h0, p[32]});
      rd(16'h0068, d); chk(d, {31'h0, p[33]});
      rd(16'h006C, d); chk(d, {31'h0, p[34]});
    end
    wr(16'h0060, 32'hFFFF_FFFF);
    wr(16'h0068, 32'hFFFF_FFFF);
    rd(16'h0060, d); chk(d, p[31:0]);
    rd(16'h0068, d); chk(d, {31'h0, p[33]});
    rd(16'h0080, d); chk(d, 32'h0);
    close_out();
  end
endmodule : test_front_panel_io_value_status

// File: verilog/fpio_pkg.sv
package fpio_pkg;
  localparam int          DATA_W           = 32;
  localparam int          ADDR_W           = 16;
  localparam int          SYNC_STAGES      = 2;
  // register offsets (byte addresses)
  localparam logic [15:0] OFS_LVDS_SEL     = 16'h0010;
  localparam logic [15:0] OFS_MEZZ_SEL     = 16'h0014;
  localparam logic [15:0] OFS_LVDS_VALUE   = 16'h0040;
  localparam logic [15:0] OFS_MEZZ_VALUE   = 16'h0044;
  localparam logic [15:0] OFS_MEZZ_IN      = 16'h0060;
  localparam logic [15:0] OFS_TRIG_ONE     = 16'h0064;
  localparam logic [15:0] OFS_TRIG_TWO     = 16'h0068;
  localparam logic [15:0] OFS_SYNC         = 16'h006C;
  // reset values and field layout
  localparam logic [31:0] RST_VALUE        = 32'h00000000;
  localparam int          LINE_BIT         = 0;
  localparam logic [31:0] READ_ZERO        = 32'h00000000;
  // number of synchronised single lines: trigger one, trigger two, sync
  localparam int          LINE_COUNT       = 3;
  localparam int          IDX_TRIG_ONE     = 0;
  localparam int          IDX_TRIG_TWO     = 1;
  localparam int          IDX_SYNC         = 2;
endpackage : fpio_pkg

// File: verilog/fpio_regs.sv
`timescale 1ns/1ps
// Behaviour
// - register-selected lvds bits driven from value register
// - register-selected mezzanine bits driven from value register
// - mezzanine input register reads input levels after the two-flop synchroniser
// - trigger-one register bit 0 reads line level
// - trigger-two register bit 0 reads line level
// - sync register bit 0 reads line level
// - lvds select bit one picks user logic
// - mezzanine select bit one picks user logic
module fpio_regs #(
  parameter int BUS_W = 32                          // width of each output bus
) (
  input  wire logic             mclk,               // system clock, 40 MHz
  input  wire logic             srst,               // synchronous reset, active high
  input  wire logic             regWrite,           // write strobe, one cycle
  input  wire logic             regRead,            // read strobe, one cycle
  input  wire logic [15:0]      regAddr,            // byte address
  input  wire logic [31:0]      regWdata,           // write data
  output logic      [31:0]      regRdata,           // read data, registered
  output logic                  regRdValid,         // read data valid pulse
  input  wire logic [BUS_W-1:0] userLvds,           // user logic lvds drive
  input  wire logic [BUS_W-1:0] userMezz,           // user logic mezzanine drive
  output logic      [BUS_W-1:0] lvdsOut,            // front panel lvds output bus
  output logic      [BUS_W-1:0] mezzOut,            // mezzanine output bus
  input  wire logic [BUS_W-1:0] mezzIn,             // mezzanine input bus pins
  input  wire logic             triggerOneLine,     // backplane trigger one pin
  input  wire logic             triggerTwoLine,     // backplane trigger two pin
  input  wire logic             syncLine            // backplane sync pin
);
  localparam int SW = BUS_W + fpio_pkg::LINE_COUNT;

  logic [BUS_W-1:0] lvdsOutSourceSelect;
  logic [BUS_W-1:0] mezzanineOutSourceSelect;
  logic [BUS_W-1:0] lvdsOutValue;
  logic [BUS_W-1:0] mezzanineOutValue;
  logic [BUS_W-1:0] mezzInLevel;
  logic [fpio_pkg::LINE_COUNT-1:0] lineLevel;
  logic [31:0]      next_regRdata;

  fpio_sync_if #(.WIDTH(SW)) syncBus ();

  // pins cross into mclk before any logic looks at them
  assign syncBus.raw = {mezzIn, syncLine, triggerTwoLine, triggerOneLine};

  fpio_sync #(.WIDTH(SW)) u_sync (
    .mclk (mclk),
    .srst (srst),
    .bus  (syncBus.sampler)
  );

  assign lineLevel   = syncBus.level[fpio_pkg::LINE_COUNT-1:0];
  assign mezzInLevel = syncBus.level[SW-1:fpio_pkg::LINE_COUNT];

  // per-bit source mux: one selects user logic, zero the value register
  function automatic logic [BUS_W-1:0] pickSource(input logic [BUS_W-1:0] sel,
                                                  input logic [BUS_W-1:0] user,
                                                  input logic [BUS_W-1:0] value);
    pickSource = (sel & user) | (~sel & value);
  endfunction : pickSource

  // single line placed in its bit, everything above reads zero
  function automatic logic [31:0] lineWord(input logic line);
    lineWord = fpio_pkg::READ_ZERO;
    lineWord[fpio_pkg::LINE_BIT] = line;
  endfunction : lineWord

  // offsets that answer with a level and take no write
  function automatic logic isReadOnly(input logic [15:0] addr);
    isReadOnly = (addr == fpio_pkg::OFS_MEZZ_IN) || (addr == fpio_pkg::OFS_TRIG_ONE) ||
                 (addr == fpio_pkg::OFS_TRIG_TWO) || (addr == fpio_pkg::OFS_SYNC);
  endfunction : isReadOnly

  // every offset this block decodes; anything else reads zero
  function automatic logic isMapped(input logic [15:0] addr);
    isMapped = isReadOnly(addr) || (addr == fpio_pkg::OFS_LVDS_SEL) || (addr == fpio_pkg::OFS_MEZZ_SEL) ||
               (addr == fpio_pkg::OFS_LVDS_VALUE) || (addr == fpio_pkg::OFS_MEZZ_VALUE);
  endfunction : isMapped

  // select registers; writes to read-only offsets fall through untouched
  always_ff @(posedge mclk) begin
    if (srst) begin
      lvdsOutSourceSelect      <= BUS_W'(fpio_pkg::RST_VALUE);
      mezzanineOutSourceSelect <= BUS_W'(fpio_pkg::RST_VALUE);
    end else if (regWrite) begin
      if (regAddr == fpio_pkg::OFS_LVDS_SEL)
        lvdsOutSourceSelect <= regWdata[BUS_W-1:0];
      if (regAddr == fpio_pkg::OFS_MEZZ_SEL)
        mezzanineOutSourceSelect <= regWdata[BUS_W-1:0];
    end
  end

  // static value registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      lvdsOutValue      <= BUS_W'(fpio_pkg::RST_VALUE);
      mezzanineOutValue <= BUS_W'(fpio_pkg::RST_VALUE);
    end else if (regWrite) begin
      if (regAddr == fpio_pkg::OFS_LVDS_VALUE)
        lvdsOutValue <= regWdata[BUS_W-1:0];
      if (regAddr == fpio_pkg::OFS_MEZZ_VALUE)
        mezzanineOutValue <= regWdata[BUS_W-1:0];
    end
  end

  // output buses are flopped so no mux glitch reaches the pins; costs one cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      lvdsOut <= '0;
      mezzOut <= '0;
    end else begin
      lvdsOut <= pickSource(lvdsOutSourceSelect, userLvds, lvdsOutValue);
      mezzOut <= pickSource(mezzanineOutSourceSelect, userMezz, mezzanineOutValue);
    end
  end

  // read decode; unmapped offsets return zero
  always_comb begin
    next_regRdata = fpio_pkg::READ_ZERO;
    case (regAddr)
      fpio_pkg::OFS_LVDS_SEL: next_regRdata = 32'(lvdsOutSourceSelect);
      fpio_pkg::OFS_MEZZ_SEL: next_regRdata = 32'(mezzanineOutSourceSelect);
      fpio_pkg::OFS_LVDS_VALUE: next_regRdata = 32'(lvdsOutValue);
      fpio_pkg::OFS_MEZZ_VALUE: next_regRdata = 32'(mezzanineOutValue);
      fpio_pkg::OFS_MEZZ_IN:    next_regRdata = 32'(mezzInLevel);
      fpio_pkg::OFS_TRIG_ONE:   next_regRdata = lineWord(lineLevel[fpio_pkg::IDX_TRIG_ONE]);
      fpio_pkg::OFS_TRIG_TWO:   next_regRdata = lineWord(lineLevel[fpio_pkg::IDX_TRIG_TWO]);
      fpio_pkg::OFS_SYNC:       next_regRdata = lineWord(lineLevel[fpio_pkg::IDX_SYNC]);
      default:                next_regRdata = fpio_pkg::READ_ZERO;
    endcase
  end

  // read data holds until the next read
  always_ff @(posedge mclk) begin
    if (srst) begin
      regRdata   <= fpio_pkg::READ_ZERO;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRead;
      if (regRead)
        regRdata <= next_regRdata;
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // whole-bus register drive: a written value reaches the pins one edge after the taking edge
  a_lvds_reg_drive: assert property (
    (regWrite && regAddr == fpio_pkg::OFS_LVDS_VALUE && lvdsOutSourceSelect == '0) ##1
    (lvdsOutSourceSelect == '0 && !regWrite) |=> lvdsOut == $past(regWdata[BUS_W-1:0], 2))
    else $error("lvds output does not follow written value");
  a_mezz_reg_drive: assert property (
    (regWrite && regAddr == fpio_pkg::OFS_MEZZ_VALUE && mezzanineOutSourceSelect == '0) ##1
    (mezzanineOutSourceSelect == '0 && !regWrite) |=> mezzOut == $past(regWdata[BUS_W-1:0], 2))
    else $error("mezzanine output does not follow written value");

  // value writes land in the register at the taking edge
  a_lvds_value_write: assert property (
    regWrite && regAddr == fpio_pkg::OFS_LVDS_VALUE |=>
    lvdsOutValue == $past(regWdata[BUS_W-1:0]))
    else $error("lvds value write lost");
  a_mezz_value_write: assert property (
    regWrite && regAddr == fpio_pkg::OFS_MEZZ_VALUE |=>
    mezzanineOutValue == $past(regWdata[BUS_W-1:0]))
    else $error("mezzanine value write lost");

  // per bit: a cleared select bit passes the value register, mixed selects included
  a_lvds_value_bits: assert property (
    lvdsOutSourceSelect != '1 |=>
    (lvdsOut & ~$past(lvdsOutSourceSelect)) == ($past(lvdsOutValue) & ~$past(lvdsOutSourceSelect)))
    else $error("lvds register-driven bit wrong");
  a_mezz_value_bits: assert property (
    mezzanineOutSourceSelect != '1 |=>
    (mezzOut & ~$past(mezzanineOutSourceSelect)) ==
    ($past(mezzanineOutValue) & ~$past(mezzanineOutSourceSelect)))
    else $error("mezzanine register-driven bit wrong");

  // per bit: a set select bit passes user logic; needs no all-ones select to fire
  a_lvds_user_sel: assert property (
    lvdsOutSourceSelect != '0 |=>
    (lvdsOut & $past(lvdsOutSourceSelect)) == ($past(userLvds) & $past(lvdsOutSourceSelect)))
    else $error("lvds user source not passed");
  a_mezz_user_sel: assert property (
    mezzanineOutSourceSelect != '0 |=>
    (mezzOut & $past(mezzanineOutSourceSelect)) == ($past(userMezz) & $past(mezzanineOutSourceSelect)))
    else $error("mezzanine user source not passed");

  // select writes land in the register at the taking edge
  a_lvds_sel_write: assert property (
    regWrite && regAddr == fpio_pkg::OFS_LVDS_SEL |=>
    lvdsOutSourceSelect == $past(regWdata[BUS_W-1:0]))
    else $error("lvds select write lost");
  a_mezz_sel_write: assert property (
    regWrite && regAddr == fpio_pkg::OFS_MEZZ_SEL |=>
    mezzanineOutSourceSelect == $past(regWdata[BUS_W-1:0]))
    else $error("mezzanine select write lost");

  // level reads return the synchronised level present at the taking edge
  a_mezz_in_read: assert property (
    regRead && regAddr == fpio_pkg::OFS_MEZZ_IN |=> regRdValid && regRdata == 32'($past(mezzInLevel)))
    else $error("mezzanine input read wrong");
  a_trig_one_read: assert property (
    regRead && regAddr == fpio_pkg::OFS_TRIG_ONE |=>
    regRdata[fpio_pkg::LINE_BIT] == $past(lineLevel[fpio_pkg::IDX_TRIG_ONE]))
    else $error("trigger one read wrong");
  a_trig_two_read: assert property (
    regRead && regAddr == fpio_pkg::OFS_TRIG_TWO |=>
    regRdata[fpio_pkg::LINE_BIT] == $past(lineLevel[fpio_pkg::IDX_TRIG_TWO]))
    else $error("trigger two read wrong");
  a_sync_read: assert property (
    regRead && regAddr == fpio_pkg::OFS_SYNC ##1 !regRead |-> ##1 regRdata[0] == $past(syncLine, 4))
    else $error("sync read wrong");

  // read port: one valid pulse per strobe, data held between reads
  a_rd_valid_pulse: assert property (
    regRdValid == $past(regRead))
    else $error("read valid not one edge after strobe");
  a_rdata_hold: assert property (
    !regRead |=> $stable(regRdata))
    else $error("read data moved without a read");

  // unused and unmapped positions read zero; read-only offsets take no write
  a_line_upper_zero: assert property (
    regRead && isReadOnly(regAddr) && regAddr != fpio_pkg::OFS_MEZZ_IN |=> regRdata[31:1] == '0)
    else $error("unused line bits not zero");
  a_unmapped_zero: assert property (
    regRead && !isMapped(regAddr) |=> regRdata == fpio_pkg::READ_ZERO)
    else $error("unmapped read not zero");
  a_ro_write_ignored: assert property (
    regWrite && isReadOnly(regAddr) |=> $stable(lvdsOutValue) && $stable(mezzanineOutValue) &&
    $stable(lvdsOutSourceSelect) && $stable(mezzanineOutSourceSelect))
    else $error("read-only write changed state");

  c_lvds_write: cover property (regWrite && regAddr == fpio_pkg::OFS_LVDS_VALUE);
  c_mixed_sel: cover property (lvdsOutSourceSelect != '0 && lvdsOutSourceSelect != '1);
  c_trig_high_read: cover property (regRead && regAddr == fpio_pkg::OFS_TRIG_ONE ##1 regRdata[0]);
  c_back_to_back: cover property (regRead [*2]);
  c_user_drive: cover property (lvdsOutSourceSelect != '0 ##1 lvdsOut != '0);
endmodule : fpio_regs

// File: verilog/fpio_sync.sv
`timescale 1ns/1ps
module fpio_sync #(
  parameter int WIDTH = 35                 // bits to synchronise
) (
  input  wire logic mclk,                  // system clock
  input  wire logic srst,                  // synchronous reset, active high
  fpio_sync_if.sampler bus                 // raw in, level out
);
  logic [WIDTH-1:0] stageOne;
  logic [WIDTH-1:0] stageTwo;

  // two-flop synchroniser; stageOne is read by stageTwo only
  always_ff @(posedge mclk) begin
    if (srst) begin
      stageOne <= '0;
      stageTwo <= '0;
    end else begin
      stageOne <= bus.raw;
      stageTwo <= stageOne;
    end
  end

  assign bus.level = stageTwo;
endmodule : fpio_sync

// File: verilog/fpio_sync_if.sv
`timescale 1ns/1ps
// raw pin levels in, synchronised levels out
interface fpio_sync_if #(parameter int WIDTH = 35);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] level;
  modport sampler (input raw, output level);
  modport user    (output raw, input level);
endinterface : fpio_sync_if
